// [rtl/sad_pkg.sv]
// sad_pkg: constants and types for the segment and scale-index-base decoder.
// assumes a core with 32-bit general registers and six segment registers.
package sad_pkg;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int MOD_HI   = 7;
  localparam int MOD_LO   = 6;
  localparam int RM_HI    = 2;
  localparam int RM_LO    = 0;
  localparam int SS_HI    = 7;
  localparam int SS_LO    = 6;
  localparam int IDX_HI   = 5;
  localparam int IDX_LO   = 3;
  localparam int BASE_HI  = 2;
  localparam int BASE_LO  = 0;

  // ----------------------------------------------------------------
  // special codes
  // ----------------------------------------------------------------
  localparam logic [1:0] MOD_NODISP = 2'h0;
  localparam logic [1:0] MOD_D8     = 2'h1;
  localparam logic [1:0] MOD_D32    = 2'h2;
  localparam logic [1:0] MOD_REG    = 2'h3;
  localparam logic [2:0] RM_SIB     = 3'h4;
  localparam logic [2:0] IDX_NONE   = 3'h4;
  localparam logic [1:0] SS_X1      = 2'h0;
  localparam logic [2:0] BASE_ESP   = 3'h4;
  localparam logic [2:0] BASE_EBP   = 3'h5;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    SAD_SEG_ES   = 3'h0,
    SAD_SEG_CS   = 3'h1,
    SAD_SEG_SS   = 3'h2,
    SAD_SEG_DS   = 3'h3,
    SAD_SEG_FS   = 3'h4,
    SAD_SEG_GS   = 3'h5,
    SAD_SEG_NONE = 3'h7
  } sad_seg_e;

  typedef enum logic [2:0] {
    SAD_R_EAX = 3'h0,
    SAD_R_ECX = 3'h1,
    SAD_R_EDX = 3'h2,
    SAD_R_EBX = 3'h3,
    SAD_R_ESP = 3'h4,
    SAD_R_EBP = 3'h5,
    SAD_R_ESI = 3'h6,
    SAD_R_EDI = 3'h7
  } sad_gpr_e;

  typedef enum logic [1:0] {
    SAD_D_NONE = 2'h0,
    SAD_D_8    = 2'h1,
    SAD_D_16   = 2'h2,
    SAD_D_32   = 2'h3
  } sad_disp_e;

  typedef struct packed {
    logic        valid;
    sad_seg_e    seg2;
    sad_seg_e    seg3;
    logic        sib_present;
    logic [1:0]  scale_shift;
    logic        index_used;
    sad_gpr_e    index_reg;
    logic        base_used;
    sad_gpr_e    base_reg;
    sad_seg_e    def_seg;
    sad_disp_e   disp_size;
    logic [31:0] disp;
    logic        ea_undef;
  } sad_dec_s;

  localparam sad_dec_s DEC_RESET = '{
    valid: 1'b0, seg2: SAD_SEG_ES, seg3: SAD_SEG_ES, sib_present: 1'b0,
    scale_shift: 2'h0, index_used: 1'b0, index_reg: SAD_R_EAX,
    base_used: 1'b0, base_reg: SAD_R_EAX, def_seg: SAD_SEG_DS,
    disp_size: SAD_D_NONE, disp: 32'h0000_0000, ea_undef: 1'b0};

endpackage : sad_pkg

// [rtl/sad_decode.sv]
// sad_decode: registered decode of segment-select fields and the scale-index-base byte.
// assumes fetch hands over whole bytes on the core clock, displacement bytes already gathered.
`timescale 1ns/1ns
`default_nettype none
module sad_decode
  import sad_pkg::*;
(
  input  wire logic        sys_clk_i,
  input  wire logic        rst_b_i,
  input  wire logic        valid_i,
  input  wire logic        addr32_i,
  input  wire logic [1:0]  seg_select_two_bit_i,
  input  wire logic [2:0]  seg_select_three_bit_i,
  input  wire logic [7:0]  modrm_i,
  input  wire logic [7:0]  sib_i,
  input  wire logic [31:0] disp_raw_i,
  output logic             valid_o,
  output logic [2:0]       seg2_o,
  output logic [2:0]       seg3_o,
  output logic             sib_present_o,
  output logic [1:0]       scale_shift_o,
  output logic             index_used_o,
  output logic [2:0]       index_reg_o,
  output logic             base_used_o,
  output logic [2:0]       base_reg_o,
  output logic [2:0]       def_seg_o,
  output logic [1:0]       disp_size_o,
  output logic [31:0]      disp_o,
  output logic             ea_undef_o
);

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  sad_dec_s   dec_reg;
  sad_dec_s   dec_next;
  logic [1:0] mod_f;
  logic [2:0] rm_f;
  logic [1:0] ss_f;
  logic [2:0] idx_f;
  logic [2:0] base_f;

  assign mod_f  = modrm_i[MOD_HI:MOD_LO];
  assign rm_f   = modrm_i[RM_HI:RM_LO];
  assign ss_f   = sib_i[SS_HI:SS_LO];
  assign idx_f  = sib_i[IDX_HI:IDX_LO];
  assign base_f = sib_i[BASE_HI:BASE_LO];

  always_comb
  begin
    dec_next       = DEC_RESET;
    dec_next.valid = valid_i;
    dec_next.seg2  = sad_seg_e'({1'b0, seg_select_two_bit_i});
    case (seg_select_three_bit_i)
      3'h6, 3'h7: dec_next.seg3 = SAD_SEG_NONE;
      default:    dec_next.seg3 = sad_seg_e'(seg_select_three_bit_i);
    endcase
    dec_next.sib_present = addr32_i && (rm_f == RM_SIB) && (mod_f != MOD_REG);
    if (dec_next.sib_present)
    begin
      // scale code doubles as a left-shift amount
      dec_next.scale_shift = ss_f;
      dec_next.index_used  = (idx_f != IDX_NONE);
      dec_next.index_reg   = sad_gpr_e'(idx_f);
      dec_next.ea_undef    = (idx_f == IDX_NONE) && (ss_f != SS_X1);
      dec_next.base_reg    = sad_gpr_e'(base_f);
      dec_next.base_used   = 1'b1;
      dec_next.def_seg     = SAD_SEG_DS;
      case (mod_f)
        MOD_NODISP:
        begin
          dec_next.disp_size = SAD_D_NONE;
          if (base_f == BASE_ESP)
            dec_next.def_seg = SAD_SEG_SS;
          if (base_f == BASE_EBP)
          begin
            dec_next.base_used = 1'b0;
            dec_next.disp_size = SAD_D_32;
          end
        end
        MOD_D8, MOD_D32:
        begin
          dec_next.disp_size = (mod_f == MOD_D8) ? SAD_D_8 : SAD_D_32;
          if ((base_f == BASE_ESP) || (base_f == BASE_EBP))
            dec_next.def_seg = SAD_SEG_SS;
        end
        default:
          dec_next.disp_size = SAD_D_NONE;
      endcase
      case (dec_next.disp_size)
        SAD_D_8:  dec_next.disp = {{24{disp_raw_i[7]}}, disp_raw_i[7:0]};
        SAD_D_32: dec_next.disp = disp_raw_i;
        default:  dec_next.disp = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_b_i)
      dec_reg <= DEC_RESET;
    else
      dec_reg <= dec_next;
  end

  assign valid_o       = dec_reg.valid;
  assign seg2_o        = dec_reg.seg2;
  assign seg3_o        = dec_reg.seg3;
  assign sib_present_o = dec_reg.sib_present;
  assign scale_shift_o = dec_reg.scale_shift;
  assign index_used_o  = dec_reg.index_used;
  assign index_reg_o   = dec_reg.index_reg;
  assign base_used_o   = dec_reg.base_used;
  assign base_reg_o    = dec_reg.base_reg;
  assign def_seg_o     = dec_reg.def_seg;
  assign disp_size_o   = dec_reg.disp_size;
  assign disp_o        = dec_reg.disp;
  assign ea_undef_o    = dec_reg.ea_undef;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);

  sequence s_sib_in;
    addr32_i && (modrm_i[2:0] == 3'h4) && (modrm_i[7:6] != 2'h3);
  endsequence

  a_seg2_map: assert property (
    ##1 $past(rst_b_i) |-> seg2_o == {1'b0, $past(seg_select_two_bit_i)})
    else $error("two-bit segment select wrong");
  a_seg3_undef: assert property (
    $past(rst_b_i) && $past(seg_select_three_bit_i[2:1]) == 2'h3 |-> seg3_o == 3'h7)
    else $error("three-bit code 110/111 not undefined");
  a_sib_detect: assert property (
    s_sib_in |=> sib_present_o)
    else $error("sib byte not expected");
  a_no_sib: assert property (
    !addr32_i |=> !sib_present_o && disp_size_o == 2'h0)
    else $error("sib decoded in 16-bit mode");
  a_scale_pass: assert property (
    s_sib_in |=> scale_shift_o == $past(sib_i[7:6]))
    else $error("scale factor wrong");
  a_index_none: assert property (
    s_sib_in and (sib_i[5:3] == 3'h4) |=> !index_used_o)
    else $error("index 100 still used");
  a_ea_undef: assert property (
    s_sib_in and (sib_i[5:3] == 3'h4) and (sib_i[7:6] != 2'h0) |=> ea_undef_o)
    else $error("undefined address not flagged");
  a_mod0_d32: assert property (
    s_sib_in and (modrm_i[7:6] == 2'h0) and (sib_i[2:0] == 3'h5) |=> !base_used_o && disp_size_o == 2'h3)
    else $error("mod 00 base 101 not d32");
  a_ebp_ss: assert property (
    s_sib_in and (modrm_i[7:6] != 2'h0) and (sib_i[2:0] == 3'h5) |=> def_seg_o == 3'h2 && base_reg_o == 3'h5)
    else $error("EBP base not SS");
  a_d8_sext: assert property (
    s_sib_in and (modrm_i[7:6] == 2'h1) |=>
      disp_size_o == 2'h1 && disp_o == {{24{$past(disp_raw_i[7])}}, $past(disp_raw_i[7:0])})
    else $error("d8 not sign-extended");
  a_ds_default: assert property (
    s_sib_in and (sib_i[2:1] != 2'h2) |=> def_seg_o == 3'h3)
    else $error("default segment not DS");

  // ----------------------------------------------------------------
  // field and no-sib checks
  // ----------------------------------------------------------------
  sequence s_no_sib_in;
    !addr32_i || (modrm_i[2:0] != 3'h4) || (modrm_i[7:6] == 2'h3);
  endsequence

  sequence s_base_reg_in;
    (modrm_i[7:6] != 2'h0) || (sib_i[2:0] != 3'h5);
  endsequence

  a_valid_pipe: assert property (
    1'b1 |=> valid_o == $past(valid_i))
    else $error("valid not carried one cycle");
  a_seg3_map: assert property (
    seg_select_three_bit_i[2:1] != 2'h3 |=> seg3_o == $past(seg_select_three_bit_i))
    else $error("three-bit segment select wrong");
  a_index_reg: assert property (
    s_sib_in and (sib_i[5:3] != 3'h4) |=> index_used_o && index_reg_o == $past(sib_i[5:3]))
    else $error("index register wrong");
  a_ea_defined: assert property (
    s_sib_in and ((sib_i[5:3] != 3'h4) || (sib_i[7:6] == 2'h0)) |=> !ea_undef_o)
    else $error("defined address flagged undefined");
  a_base_reg: assert property (
    s_sib_in and s_base_reg_in |=> base_used_o && base_reg_o == $past(sib_i[2:0]))
    else $error("base register wrong");
  a_esp_ss: assert property (
    s_sib_in and (sib_i[2:0] == 3'h4) |=> def_seg_o == 3'h2)
    else $error("ESP base not SS");
  a_mod0_nodisp: assert property (
    s_sib_in and (modrm_i[7:6] == 2'h0) and (sib_i[2:0] != 3'h5) |=> disp_size_o == 2'h0 && disp_o == 32'h0000_0000)
    else $error("mod 00 carries displacement");
  a_mod0_d32_pass: assert property (
    s_sib_in and (modrm_i[7:6] == 2'h0) and (sib_i[2:0] == 3'h5) |=> disp_o == $past(disp_raw_i))
    else $error("mod 00 d32 value wrong");
  a_d32_pass: assert property (
    s_sib_in and (modrm_i[7:6] == 2'h2) |=> disp_size_o == 2'h3 && disp_o == $past(disp_raw_i))
    else $error("mod 10 d32 wrong");
  a_no_d16: assert property (
    1'b1 |=> disp_size_o != 2'h2)
    else $error("d16 size produced");
  a_no_sib_quiet: assert property (
    s_no_sib_in |=> !sib_present_o && scale_shift_o == 2'h0 && !index_used_o && !base_used_o && !ea_undef_o)
    else $error("sib fields set without sib byte");
  a_no_sib_ds: assert property (
    s_no_sib_in |=> def_seg_o == 3'h3 && disp_size_o == 2'h0 && disp_o == 32'h0000_0000)
    else $error("no-sib form not DS without displacement");

endmodule : sad_decode
`default_nettype wire

// [verification/sad_fetch_model.sv]
// sad_fetch_model: stands in for the fetch stage that feeds the decoder.
// assumes each put is called just after a rising clock edge.
`timescale 1ns/1ns
`default_nettype none
module sad_fetch_model
  import sad_pkg::*;
(
  output logic        valid_o,
  output logic        addr32_o,
  output logic [1:0]  seg2_o,
  output logic [2:0]  seg3_o,
  output logic [7:0]  modrm_o,
  output logic [7:0]  sib_o,
  output logic [31:0] disp_o
);
  initial
  begin
    {valid_o, addr32_o, seg2_o, seg3_o, modrm_o, sib_o, disp_o} = '0;
  end
  // whole bytes and displacement handed over at once
  task automatic put(input logic v, input logic a, input logic [2:0] s, input logic [7:0] m,
                     input logic [7:0] b, input logic [31:0] d);
    {valid_o, addr32_o, seg2_o, seg3_o, modrm_o, sib_o, disp_o} = {v, a, s[1:0], s, m, b, d};
  endtask : put
endmodule : sad_fetch_model
`default_nettype wire

// [verification/segment_and_sib_address_decode_tb.sv]
// segment_and_sib_address_decode_tb: self-checking bench for sad_decode.
// assumes one-cycle registered answer and synchronous active-low reset.
`timescale 1ns/1ns
`default_nettype none
module segment_and_sib_address_decode_tb;
  import sad_pkg::*;
  logic        sys_clk_i = 1'b0;
  logic        rst_b_i = 1'b0;
  logic        vin, ain, vld = 1'b0;
  logic [1:0]  s2in;
  logic [2:0]  s3in;
  logic [7:0]  min, bin;
  logic [31:0] din, dp_o;
  logic        v_o, sp_o, iu_o, bu_o, eu_o;
  logic [2:0]  s2_o, s3_o, ir_o, br_o, ds_o;
  logic [1:0]  sc_o, dz_o;
  int          failures = 0;
  int          checks_done = 0;
  int          cycles = 0;

  always #5 sys_clk_i = ~sys_clk_i;

  sad_fetch_model sad_fetch_model_i (.valid_o(vin), .addr32_o(ain), .seg2_o(s2in), .seg3_o(s3in),
    .modrm_o(min), .sib_o(bin), .disp_o(din));
  sad_decode sad_decode_i (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .valid_i(vin), .addr32_i(ain),
    .seg_select_two_bit_i(s2in), .seg_select_three_bit_i(s3in), .modrm_i(min), .sib_i(bin),
    .disp_raw_i(din), .valid_o(v_o), .seg2_o(s2_o), .seg3_o(s3_o), .sib_present_o(sp_o),
    .scale_shift_o(sc_o), .index_used_o(iu_o), .index_reg_o(ir_o), .base_used_o(bu_o),
    .base_reg_o(br_o), .def_seg_o(ds_o), .disp_size_o(dz_o), .disp_o(dp_o), .ea_undef_o(eu_o));

  task automatic close_out();
    if (failures == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : close_out

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  // one request, answer checked one edge later
  task automatic run(input logic a, input logic [2:0] s, input logic [7:0] m, input logic [7:0] b,
                     input logic [31:0] d);
    logic        sib, iu, bu, ss;
    logic [1:0]  mo, dz;
    logic [2:0]  ix, bs;
    logic [31:0] dx;
    mo = m[7:6];
    ix = b[5:3];
    bs = b[2:0];
    sib = a && m[2:0] == 3'h4 && mo != 2'h3;
    iu = sib && ix != 3'h4;
    bu = sib && !(mo == 2'h0 && bs == 3'h5);
    ss = sib && (bs == 3'h4 || (bs == 3'h5 && mo != 2'h0));
    dz = !sib ? 2'h0 : mo == 2'h1 ? 2'h1 : (mo == 2'h2 || !bu) ? 2'h3 : 2'h0;
    dx = dz == 2'h1 ? {{24{d[7]}}, d[7:0]} : dz == 2'h3 ? d : 32'h0000_0000;
    vld = ~vld;
    sad_fetch_model_i.put(vld, a, s, m, b, d);
    @(posedge sys_clk_i);
    #1;
    check("valid", 32'(v_o), 32'(vld));
    check("seg2", 32'(s2_o), 32'(s[1:0]));
    check("seg3", 32'(s3_o), 32'(s[2:1] == 2'h3 ? 3'h7 : s));
    check("sib", 32'(sp_o), 32'(sib));
    check("scale", 32'(sc_o), 32'(sib ? b[7:6] : 2'h0));
    check("index", 32'({iu_o, iu ? ir_o : 3'h0}), 32'({iu, iu ? ix : 3'h0}));
    check("undef", 32'(eu_o), 32'(sib && ix == 3'h4 && b[7:6] != 2'h0));
    check("base", 32'({bu_o, bu ? br_o : 3'h0}), 32'({bu, bu ? bs : 3'h0}));
    check("defseg", 32'(ds_o), 32'(ss ? 3'h2 : 3'h3));
    check("dsize", 32'(dz_o), 32'(dz));
    check("disp", dp_o, dx);
  endtask : run

  always @(posedge sys_clk_i)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      failures++;
      close_out();
    end
  end

  initial
  begin
    repeat (20) @(posedge sys_clk_i);
    #1;
    check("reset", 32'({v_o, sp_o, sc_o, iu_o, bu_o, eu_o, dz_o, ds_o}), 32'h0000_0003);
    check("reset disp", dp_o, 32'h0000_0000);
    rst_b_i = 1'b1;
    for (int i = 0; i < 8; i++)
      run(1'b1, i[2:0], 8'h00, 8'h00, 32'h0000_0000);
    // every sib byte under each displacement mode, sign bit of d8 both ways
    for (int i = 0; i < 1024; i++)
      run(1'b1, 3'h3, {i[9:8], 3'h2, 3'h4}, i[7:0], 32'h8765_4300 | 32'(i));
    // forms without a sib byte, plus the 32-bit rm 100 forms with mod 00/01/10 that carry sib byte FF
    for (int i = 0; i < 16; i++)
      run(i[3], 3'h6, {i[1:0], 3'h5, i[2] ? 3'h4 : 3'h1}, 8'hFF, 32'hFFFF_FF80);
    // reset in mid-run with a request standing, then the d8 example again
    rst_b_i = 1'b0;
    sad_fetch_model_i.put(1'b1, 1'b1, 3'h5, 8'h44, 8'h8D, 32'h0000_0080);
    @(posedge sys_clk_i);
    #1;
    check("mid reset", 32'({v_o, sp_o, sc_o, iu_o, bu_o, eu_o, dz_o, ds_o}), 32'h0000_0003);
    check("mid reset disp", dp_o, 32'h0000_0000);
    rst_b_i = 1'b1;
    run(1'b1, 3'h5, 8'h44, 8'h8D, 32'h0000_0080);
    close_out();
  end
endmodule : segment_and_sib_address_decode_tb
`default_nettype wire
